// ---- core/mcsi_core.sv ----
// module: start-up, low-power behaviour, interrupt flags and timer capture of the motor unit
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps

// What this block does
// R1: counter held at zero while the unit clock enable is low
// R2: setting the clock enable starts the pwm counter from zero
// R3: setting the clock enable forces all preload copies into active registers
// R4: software writes compare low then high before enabling, in 12-bit mode
// R5: forced transfer raises the update event and the pwm update flag
// R6: software stops the motor before deep-stop or wait instruction
// R7: in wait mode the unit runs unchanged and enabled events wake it
// R8: in deep-stop all registers hold and the unit stays inactive
// R9: no unit event wakes the processor from deep-stop, only from wait
// R10: ten events routed onto three interrupt vectors
// R11: request only with own enable set and global mask cleared
// R12: timer high register reads the current 8-bit up counter
// R13: sw-capture speed mode: timer high read copies timer pair into captures
// R14: speed mode: timer low holds counter low byte, 16-bit counting
// R15: previous capture: prior back-emf value, or pair low byte in speed mode
// R16: current capture: latest back-emf value, or pair high byte in speed mode
// R17: speed mode: current capture read blocks captures until previous read
// R18: current capture, next compare, demagnetization reset to zero
// R19: pwm update flag set when compares move from preload to active
// R20: enable bit 1 permits the interrupt, 0 suppresses it
// R21: flags stay set until software clears them
// R22: ratio up and ratio down share one enable bit
module mcsi_core
  import mcsi_pkg::*;
(
  // clock, reset, clock enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire mcsi_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // processor power state and global interrupt mask
  input wire mcsi_power_t power,
  // hardware events from the motor logic, indexed by flag index
  input wire logic [NUM_FLAGS-1:0] hw_events,
  // interrupt vectors and wake-up from wait
  output logic [2:0] irq_vec,
  output logic wake_wait,
  // pwm generator state
  output logic [11:0] pwm_count,
  output logic update_event,
  output logic [15:0] period_active,
  output logic [15:0] phase_u_active,
  output logic [15:0] phase_v_active,
  output logic [15:0] phase_w_active,
  output logic [7:0] pwm_config_active
);

  // advance only with clock enable and outside deep-stop
  logic run;
  assign run = clk_en & ~power.deep_stop;

  // control and software registers
  logic [7:0] ctrl_q;
  logic [7:0] enable_q;
  logic aux_en_q;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flags_d;
  logic [7:0] tim_hi_q;
  logic [7:0] tim_lo_q;
  logic [7:0] prev_cap_q;
  logic [7:0] curr_cap_q;
  logic [7:0] next_cmp_q;
  logic [7:0] demag_q;
  logic cap_lock_q;
  logic [7:0] rep_pre_q;
  logic [7:0] rep_act_q;
  logic [7:0] rep_cnt_q;
  logic [7:0] cfg_pre_q;
  logic [7:0] cfg_act_q;
  logic [15:0] cmp_pre_q [NUM_COMPARES];
  logic [15:0] cmp_act_q [NUM_COMPARES];
  logic [7:0] cmp_lo_q [NUM_COMPARES];
  logic [11:0] pwm_cnt_q;
  logic [7:0] rdata_q;

  // bus strobes qualified by the run condition
  logic wr;
  logic rd;
  assign wr = bus_req.wr & run;
  assign rd = bus_req.rd & run;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // maps the enable bytes onto one enable per flag; ratio pair shares one bit
  // R22 shared ratio enable
  function automatic logic [NUM_FLAGS-1:0] flag_enables(input logic [7:0] en,
                                                         input logic aux);
    flag_enables = {aux, en[EN_SPEED_ERR], en[EN_PWM_UPD], en[EN_RATIO],
                    en[EN_RATIO], en[4:0]};
  endfunction : flag_enables

  // start of the unit: clock enable written from 0 to 1
  logic start;
  assign start = wr & hit(bus_req.addr, OFF_CTRL) & bus_req.wdata[CTRL_UNIT_CLK_EN]
                 & ~ctrl_q[CTRL_UNIT_CLK_EN];

  logic unit_on;
  logic speed_mode;
  logic sw_capture;
  assign unit_on = ctrl_q[CTRL_UNIT_CLK_EN];
  assign speed_mode = ctrl_q[CTRL_SPEED_MODE];
  assign sw_capture = ctrl_q[CTRL_SW_CAPTURE];

  // periodic update: counter at period with repetition count exhausted
  logic wrap;
  logic periodic_xfer;
  assign wrap = unit_on & (pwm_cnt_q == cmp_act_q[CMP_PERIOD][15:4]);
  assign periodic_xfer = wrap & (rep_cnt_q == RST_BYTE);
  // R3 start forces transfer
  assign update_event = run & (start | periodic_xfer);

  // control register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= RST_BYTE;
    end else if (wr & hit(bus_req.addr, OFF_CTRL)) begin
      ctrl_q <= bus_req.wdata & CTRL_WRITE_MASK;
    end
  end

  // enable registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enable_q <= RST_BYTE;
      aux_en_q <= 1'b0;
    end else begin
      if (wr & hit(bus_req.addr, OFF_ENABLE)) begin
        enable_q <= bus_req.wdata;
      end
      if (wr & hit(bus_req.addr, OFF_AUX_ENABLE)) begin
        aux_en_q <= bus_req.wdata[AUX_EN_SAMPLING];
      end
    end
  end

  // sticky flags; writing 0 to a bit clears it, a new event in that cycle wins
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  always_comb begin
    flag_set = hw_events & {NUM_FLAGS{run}};
    // R5 update sets flag
    flag_set[FLG_PU] = hw_events[FLG_PU] | update_event;
    flag_clr = '0;
    if (wr & hit(bus_req.addr, OFF_STATUS)) begin
      flag_clr[7:0] = ~bus_req.wdata;
    end
    if (wr & hit(bus_req.addr, OFF_AUX_STATUS)) begin
      flag_clr[FLG_SE] = ~bus_req.wdata[0];
      flag_clr[FLG_SO] = ~bus_req.wdata[1];
    end
    // R21 held until cleared
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  // R19 flag register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_q <= '0;
    end else if (run) begin
      flags_q <= flags_d;
    end
  end

  // interrupt routing onto three vectors
  logic [NUM_FLAGS-1:0] pending;
  // R20 enable gating
  assign pending = flags_q & flag_enables(enable_q, aux_en_q);
  // R10 vector grouping, R11 global mask
  assign irq_vec[0] = ~power.global_mask & (pending[FLG_ES] | pending[FLG_CL]);
  assign irq_vec[1] = ~power.global_mask & (|{pending[FLG_RU], pending[FLG_RD],
                      pending[FLG_SE], pending[FLG_ZC], pending[FLG_DM], pending[FLG_CC]});
  assign irq_vec[2] = ~power.global_mask & (pending[FLG_PU] | pending[FLG_SO]);
  // R7 wait wake-up, R9 never out of deep-stop
  assign wake_wait = power.wait_mode & ~power.deep_stop & (|irq_vec);

  // pwm counter: zero while disabled, counts from zero after start
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_cnt_q <= RST_PWM_CNT;
    end else if (run) begin
      // R1 held at zero, R2 starts from zero
      if (!unit_on || wrap) begin
        pwm_cnt_q <= RST_PWM_CNT;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 12'h001;
      end
    end
  end

  // repetition down-counter, auto-reloaded from the active repetition value
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rep_cnt_q <= RST_BYTE;
    end else if (run) begin
      if (start) begin
        rep_cnt_q <= rep_pre_q;
      end else if (periodic_xfer) begin
        rep_cnt_q <= rep_act_q;
      end else if (wrap) begin
        rep_cnt_q <= rep_cnt_q - 8'h01;
      end
    end
  end

  // preload copies of repetition and configuration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rep_pre_q <= RST_BYTE;
      cfg_pre_q <= RST_BYTE;
    end else begin
      if (wr & hit(bus_req.addr, OFF_REPETITION)) begin
        rep_pre_q <= bus_req.wdata;
      end
      if (wr & hit(bus_req.addr, OFF_PWM_CONFIG)) begin
        cfg_pre_q <= bus_req.wdata;
      end
    end
  end

  // active copies of repetition and configuration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rep_act_q <= RST_BYTE;
      cfg_act_q <= RST_BYTE;
    end else if (update_event) begin
      // R3 repetition and config transfer
      rep_act_q <= rep_pre_q;
      cfg_act_q <= cfg_pre_q;
    end
  end

  // compare registers; low byte waits until the high byte completes the word,
  // so an update between the two writes still takes the old word
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COMPARES; gi++) begin : g_cmp
      localparam logic [7:0] OFF_LO = OFF_COMPARE_BASE + 8'(2 * gi);
      localparam logic [7:0] OFF_HI = OFF_COMPARE_BASE + 8'(2 * gi + 1);
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          cmp_lo_q[gi] <= RST_BYTE;
          cmp_pre_q[gi] <= RST_WORD;
        end else if (wr) begin
          if (hit(bus_req.addr, OFF_LO)) begin
            cmp_lo_q[gi] <= bus_req.wdata;
          end
          // R4 high byte commits the word
          if (hit(bus_req.addr, OFF_HI)) begin
            cmp_pre_q[gi] <= {bus_req.wdata, cmp_lo_q[gi]};
          end
        end
      end
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          cmp_act_q[gi] <= RST_WORD;
        end else if (update_event) begin
          // R3 compare transfer
          cmp_act_q[gi] <= cmp_pre_q[gi];
        end
      end
    end
  endgenerate

  // motor timer: 8-bit counter, 16-bit with the low byte in speed mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tim_hi_q <= RST_BYTE;
      tim_lo_q <= RST_BYTE;
    end else if (run) begin
      if (wr & hit(bus_req.addr, OFF_TIMER_HIGH)) begin
        tim_hi_q <= bus_req.wdata;
      end else if (wr & hit(bus_req.addr, OFF_TIMER_LOW)) begin
        tim_lo_q <= bus_req.wdata;
      end else if (unit_on) begin
        if (speed_mode) begin
          // R14 16-bit counting
          {tim_hi_q, tim_lo_q} <= {tim_hi_q, tim_lo_q} + 16'h0001;
        end else begin
          // R12 8-bit counting
          tim_hi_q <= tim_hi_q + 8'h01;
        end
      end
    end
  end

  // capture triggers
  logic sw_cap;
  logic bemf_cap;
  assign sw_cap = rd & hit(bus_req.addr, OFF_TIMER_HIGH) & speed_mode & sw_capture
                  & ~cap_lock_q;
  assign bemf_cap = run & hw_events[FLG_ZC] & ~speed_mode;

  // capture registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prev_cap_q <= RST_BYTE;
      // R18 capture reset
      curr_cap_q <= RST_BYTE;
    end else if (run) begin
      if (sw_cap) begin
        // R13 pair copy, R15 low byte, R16 high byte
        curr_cap_q <= tim_hi_q;
        prev_cap_q <= tim_lo_q;
      end else if (bemf_cap) begin
        // R15 previous value, R16 latest value
        prev_cap_q <= curr_cap_q;
        curr_cap_q <= tim_hi_q;
      end else if (wr & hit(bus_req.addr, OFF_PREV_CAPTURE)) begin
        prev_cap_q <= bus_req.wdata;
      end else if (wr & hit(bus_req.addr, OFF_CURR_CAPTURE)) begin
        curr_cap_q <= bus_req.wdata;
      end
    end
  end

  // capture lock keeps the two capture bytes coherent between reads
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_lock_q <= 1'b0;
    end else if (rd & speed_mode) begin
      // R17 lock on current read, release on previous read
      if (hit(bus_req.addr, OFF_CURR_CAPTURE)) begin
        cap_lock_q <= 1'b1;
      end else if (hit(bus_req.addr, OFF_PREV_CAPTURE)) begin
        cap_lock_q <= 1'b0;
      end
    end
  end

  // next compare and demagnetization registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // R18 reset to zero
      next_cmp_q <= RST_BYTE;
      demag_q <= RST_BYTE;
    end else begin
      if (wr & hit(bus_req.addr, OFF_NEXT_COMPARE)) begin
        next_cmp_q <= bus_req.wdata;
      end
      if (wr & hit(bus_req.addr, OFF_DEMAG)) begin
        demag_q <= bus_req.wdata;
      end
    end
  end

  // read multiplexer; compares read back the high byte of their preload copies and the last written low byte
  logic [7:0] rmux;
  logic [7:0] cidx;
  always_comb begin
    rmux = RST_BYTE;
    cidx = bus_req.addr - OFF_COMPARE_BASE;
    case (bus_req.addr)
      OFF_CTRL: rmux = ctrl_q;
      OFF_ENABLE: rmux = enable_q;
      OFF_STATUS: rmux = flags_q[7:0];
      OFF_AUX_STATUS: rmux = {6'h00, flags_q[FLG_SO], flags_q[FLG_SE]};
      OFF_AUX_ENABLE: rmux = {7'h00, aux_en_q};
      OFF_TIMER_HIGH: rmux = tim_hi_q;
      OFF_TIMER_LOW: rmux = tim_lo_q;
      OFF_PREV_CAPTURE: rmux = prev_cap_q;
      OFF_CURR_CAPTURE: rmux = curr_cap_q;
      OFF_NEXT_COMPARE: rmux = next_cmp_q;
      OFF_DEMAG: rmux = demag_q;
      OFF_REPETITION: rmux = rep_pre_q;
      OFF_PWM_CONFIG: rmux = cfg_pre_q;
      default: begin
        if (bus_req.addr >= OFF_COMPARE_BASE && bus_req.addr <= OFF_COMPARE_LAST) begin
          rmux = cidx[0] ? cmp_pre_q[cidx[2:1]][15:8] : cmp_lo_q[cidx[2:1]];
        end
      end
    endcase
  end

  // read data stands in the cycle after the strobe only; frozen with the unit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= RST_BYTE;
    end else if (run) begin
      if (rd) begin
        rdata_q <= rmux;
      end else begin
        rdata_q <= RST_BYTE;
      end
    end
  end

  assign bus_rdata = rdata_q;
  assign pwm_count = pwm_cnt_q;
  assign period_active = cmp_act_q[0];
  assign phase_u_active = cmp_act_q[1];
  assign phase_v_active = cmp_act_q[2];
  assign phase_w_active = cmp_act_q[3];
  assign pwm_config_active = cfg_act_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_start;
    run && start;
  endsequence

  sequence s_sw_read;
    run && bus_req.rd && bus_req.addr == OFF_TIMER_HIGH && speed_mode && sw_capture
    && !cap_lock_q;
  endsequence

  property p_stop_zero;
    !unit_on |-> pwm_cnt_q == RST_PWM_CNT;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("counter not zero when off"); // R1

  property p_start_zero;
    s_start |=> unit_on && pwm_cnt_q == RST_PWM_CNT;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start not from zero"); // R2

  property p_force_xfer;
    s_start |=> cmp_act_q[0] == $past(cmp_pre_q[0]) && rep_act_q == $past(rep_pre_q)
      && cfg_act_q == $past(cfg_pre_q);
  endproperty
  a_force_xfer: assert property (p_force_xfer) else $error("start missed transfer"); // R3

  property p_start_flag;
    s_start |=> flags_q[FLG_PU];
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start missed update flag"); // R5

  property p_deep_freeze;
    power.deep_stop |=> $stable(pwm_cnt_q) && $stable(flags_q) && $stable(tim_hi_q);
  endproperty
  a_deep_freeze: assert property (p_deep_freeze) else $error("state moved in deep-stop"); // R8

  property p_no_deep_wake;
    power.deep_stop |-> !wake_wait;
  endproperty
  a_no_deep_wake: assert property (p_no_deep_wake) else $error("wake from deep-stop"); // R9

  property p_mask_gate;
    power.global_mask || pending == '0 |-> irq_vec == 3'h0;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("request while masked"); // R11

  property p_enabled_req;
    !power.global_mask && flags_q[FLG_PU] && enable_q[EN_PWM_UPD] |-> irq_vec[2];
  endproperty
  a_enabled_req: assert property (p_enabled_req) else $error("enabled flag not requested"); // R20

  property p_sticky;
    run && flags_q[FLG_ZC] && !(bus_req.wr && bus_req.addr == OFF_STATUS) |=> flags_q[FLG_ZC];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // R21

  property p_sw_capture;
    s_sw_read |=> curr_cap_q == $past(tim_hi_q) && prev_cap_q == $past(tim_lo_q);
  endproperty
  a_sw_capture: assert property (p_sw_capture) else $error("timer pair not captured"); // R13

  property p_lock;
    run && bus_req.rd && speed_mode && bus_req.addr == OFF_CURR_CAPTURE |=> cap_lock_q;
  endproperty
  a_lock: assert property (p_lock) else $error("capture not locked"); // R17

endmodule : mcsi_core

// ---- core/mcsi_pkg.sv ----
// package: register map, field layout and carrier types of the motor control start-up block
package mcsi_pkg;

  // register offsets (byte addresses on the 8-bit register port)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h01;
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_AUX_STATUS = 8'h03;
  localparam logic [7:0] OFF_AUX_ENABLE = 8'h04;
  localparam logic [7:0] OFF_TIMER_HIGH = 8'h05;
  localparam logic [7:0] OFF_TIMER_LOW = 8'h06;
  localparam logic [7:0] OFF_PREV_CAPTURE = 8'h07;
  localparam logic [7:0] OFF_CURR_CAPTURE = 8'h08;
  localparam logic [7:0] OFF_NEXT_COMPARE = 8'h09;
  localparam logic [7:0] OFF_DEMAG = 8'h0a;
  localparam logic [7:0] OFF_REPETITION = 8'h0b;
  localparam logic [7:0] OFF_PWM_CONFIG = 8'h0c;
  // compare bytes: low at base + 2*n, high at base + 2*n + 1, n = period, u, v, w
  localparam logic [7:0] OFF_COMPARE_BASE = 8'h0d;
  localparam logic [7:0] OFF_COMPARE_LAST = 8'h14;

  // control register fields
  localparam int CTRL_UNIT_CLK_EN = 0;
  localparam int CTRL_SPEED_MODE = 1;
  localparam int CTRL_SW_CAPTURE = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h07;

  // flag indices; 0..7 match the status byte, 8..9 the aux status byte
  localparam int FLG_CC = 0;
  localparam int FLG_DM = 1;
  localparam int FLG_ZC = 2;
  localparam int FLG_ES = 3;
  localparam int FLG_CL = 4;
  localparam int FLG_RD = 5;
  localparam int FLG_RU = 6;
  localparam int FLG_PU = 7;
  localparam int FLG_SE = 8;
  localparam int FLG_SO = 9;
  localparam int NUM_FLAGS = 10;

  // enable register bit positions (pu, se, ratio, cl, es, zc, dm, cc)
  localparam int EN_RATIO = 5;
  localparam int EN_SPEED_ERR = 6;
  localparam int EN_PWM_UPD = 7;
  localparam int AUX_EN_SAMPLING = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [11:0] RST_PWM_CNT = 12'h000;

  localparam int NUM_COMPARES = 4;
  localparam int CMP_PERIOD = 0;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcsi_bus_req_t;

  // power state seen from the processor
  typedef struct packed {
    logic wait_mode;
    logic deep_stop;
    logic global_mask;
  } mcsi_power_t;

endpackage : mcsi_pkg

// ---- sim/mcsi_motor_model.sv ----
// partner model: motor-side source of hardware event pulses
`timescale 1ns/10ps
module mcsi_motor_model
  import mcsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // request from the bench
  input wire logic fire,
  input wire logic [3:0] idx,
  // events toward the block
  output logic [NUM_FLAGS-1:0] hw_events
);
  // one-cycle pulse; a level would set a flag again after software clears it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hw_events <= '0;
    end else begin
      hw_events <= '0;
      if (fire) begin
        hw_events[idx] <= 1'b1;
      end
    end
  end
endmodule : mcsi_motor_model

// ---- sim/mcsi_core_test.sv ----
// testbench: start-up, event flags, vectors, low-power and reset values
`timescale 1ns/10ps
module mcsi_core_test;
  import mcsi_pkg::*;
  logic ref_clk = 0, reset = 1, clk_en = 1, fire = 0, rd_d = 0;
  logic [3:0] idx = '0;
  mcsi_bus_req_t bus_req = '0;
  mcsi_power_t power = '0;
  logic [NUM_FLAGS-1:0] hw_events;
  logic [7:0] bus_rdata, pwm_config_active, cfg;
  logic [2:0] irq_vec;
  logic wake_wait, update_event;
  logic [11:0] pwm_count;
  logic [15:0] period_active, phase_u_active, phase_v_active, phase_w_active;
  logic [15:0] cmp [4];
  logic [7:0] exp_q [$];
  int failures = 0, compares = 0, cycles = 0;

  mcsi_core dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .power(power), .hw_events(hw_events), .irq_vec(irq_vec),
    .wake_wait(wake_wait), .pwm_count(pwm_count), .update_event(update_event),
    .period_active(period_active), .phase_u_active(phase_u_active),
    .phase_v_active(phase_v_active), .phase_w_active(phase_w_active),
    .pwm_config_active(pwm_config_active));
  mcsi_motor_model model (.ref_clk(ref_clk), .reset(reset), .fire(fire), .idx(idx),
    .hw_events(hw_events));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: port got %h expected %h", $time, got, exp);
    end
  endtask : chk_port

  task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: read got %h expected %h", $time, got, exp);
    end
  endtask : chk_read

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) rd_d <= bus_req.rd;
  always @(negedge ref_clk) begin
    if (rd_d === 1'b1) begin
      chk_read(bus_rdata, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : rd

  task automatic pwr(input logic w, input logic d, input logic m);
    @(posedge ref_clk);
    power <= '{wait_mode: w, deep_stop: d, global_mask: m};
    @(negedge ref_clk);
  endtask : pwr

  function automatic logic [7:0] en_of(input int i);
    if (i < 5) return 8'h01 << i;
    if (i < 7) return 8'h20;
    if (i == 7) return 8'h80;
    return (i == 8) ? 8'h40 : 8'h00;
  endfunction : en_of

  function automatic logic [2:0] vec_of(input int i);
    if (i == 3 || i == 4) return 3'b001;
    if (i == 7 || i == 9) return 3'b100;
    return 3'b010;
  endfunction : vec_of

  initial begin
    void'($urandom(97646));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // reset values and idle counter
    // zero after reset
    rd(OFF_CURR_CAPTURE, 8'h00);
    rd(OFF_NEXT_COMPARE, 8'h00);
    rd(OFF_DEMAG, 8'h00);
    rd(OFF_TIMER_HIGH, 8'h00);
    @(negedge ref_clk);
    chk_port(pwm_count, 16'h0000);
    $display("test reset done");
    // every event: flag, vector, mask, wake, persistence
    for (int i = 0; i < NUM_FLAGS; i++) begin
      wr(OFF_ENABLE, en_of(i));
      wr(OFF_AUX_ENABLE, {7'h00, i == 9});
      @(posedge ref_clk);
      idx <= 4'(i);
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk_port(irq_vec, vec_of(i));
      pwr(1'b1, 1'b0, 1'b0);
      chk_port(wake_wait, 1'b1);
      pwr(1'b1, 1'b1, 1'b0);
      chk_port(wake_wait, 1'b0);
      pwr(1'b0, 1'b0, 1'b1);
      chk_port(irq_vec, 3'b000);
      pwr(1'b0, 1'b0, 1'b0);
      rd(i < 8 ? OFF_STATUS : OFF_AUX_STATUS, 8'h01 << (i % 8));
      wr(OFF_ENABLE, 8'h00);
      wr(OFF_AUX_ENABLE, 8'h00);
      @(negedge ref_clk);
      chk_port(irq_vec, 3'b000);
      wr(OFF_STATUS, 8'h00);
      wr(OFF_AUX_STATUS, 8'h00);
    end
    // ratio down requests through the shared ratio enable
    wr(OFF_ENABLE, 8'h20);
    @(posedge ref_clk);
    idx <= 4'd5;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_port(irq_vec, 3'b010);
    wr(OFF_ENABLE, 8'h00);
    wr(OFF_STATUS, 8'h00);
    $display("test events done");
    // strobes refused in deep-stop and with the clock enable low
    // motor still stopped here
    pwr(1'b0, 1'b1, 1'b0);
    wr(OFF_NEXT_COMPARE, 8'ha5);
    pwr(1'b0, 1'b0, 1'b0);
    rd(OFF_NEXT_COMPARE, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(OFF_NEXT_COMPARE, 8'h5a);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(OFF_NEXT_COMPARE, 8'h00);
    wr(OFF_DEMAG, 8'h3c);
    rd(OFF_DEMAG, 8'h3c);
    $display("test freeze done");
    // start-up: preload low then high, then set the unit clock enable
    cfg = 8'($urandom);
    wr(OFF_PWM_CONFIG, cfg);
    wr(OFF_REPETITION, 8'($urandom));
    for (int n = 0; n < NUM_COMPARES; n++) begin
      cmp[n] = 16'($urandom);
      wr(OFF_COMPARE_BASE + 8'(2 * n), cmp[n][7:0]);
      wr(OFF_COMPARE_BASE + 8'(2 * n + 1), cmp[n][15:8]);
    end
    // the counter must reach one before its first wrap, so a high bit of the period is forced here
    cmp[CMP_PERIOD] = cmp[CMP_PERIOD] | 16'h0100;
    wr(OFF_COMPARE_BASE + 8'h01, cmp[CMP_PERIOD][15:8]);
    @(posedge ref_clk);
    bus_req <= '{addr: OFF_CTRL, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
    @(negedge ref_clk);
    chk_port(update_event, 1'b1);
    chk_port(pwm_count, 16'h0000);
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    chk_port(pwm_count, 16'h0000);
    chk_port(period_active, cmp[0]);
    chk_port(phase_u_active, cmp[1]);
    chk_port(phase_v_active, cmp[2]);
    chk_port(phase_w_active, cmp[3]);
    chk_port(pwm_config_active, cfg);
    @(negedge ref_clk);
    chk_port(pwm_count, 16'h0001);
    rd(OFF_STATUS, 8'h80);
    $display("test startup done");
    // speed mode with software captures: pair copy and read lock
    wr(OFF_CTRL, 8'h07);
    wr(OFF_TIMER_LOW, 8'hf0);
    wr(OFF_TIMER_HIGH, 8'h12);
    // low byte counts every cycle except the high-byte write cycle
    rd(OFF_TIMER_HIGH, 8'h12);
    rd(OFF_CURR_CAPTURE, 8'h12);
    rd(OFF_TIMER_HIGH, 8'h12);
    rd(OFF_PREV_CAPTURE, 8'hf2);
    rd(OFF_TIMER_LOW, 8'hfa);
    $display("test capture done");
    repeat (2) @(posedge ref_clk);
    test_done();
  end
endmodule : mcsi_core_test
